// *** logic/afc_pkg.sv ***
// Constants and types for the first-slot front-end configuration bank.
// Assumes a single 125 MHz clock and an 8-bit word-addressed 16-bit register port.
package afc_pkg;

    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 16;
    localparam int GAIN_W  = 2;
    localparam int KOHM_W  = 8;
    localparam int NUM_CH  = 4;

    // Register offsets as printed
    localparam logic [7:0] ADDR_WINDOW = 8'h39;
    localparam logic [7:0] ADDR_MODE   = 8'h42;
    localparam logic [7:0] ADDR_PATH   = 8'h43;
    localparam logic [7:0] ADDR_GAIN   = 8'h55;

    // Reset values, assembled from the field defaults
    localparam logic [15:0] RST_WINDOW = 16'h22fc;
    localparam logic [15:0] RST_MODE   = 16'h1c38;
    localparam logic [15:0] RST_PATH   = 16'hada5;
    localparam logic [15:0] RST_GAIN   = 16'h0000;

    // Window timing fields
    localparam int WIDTH_LSB  = 11;
    localparam int WIDTH_W    = 5;
    localparam int COARSE_LSB = 5;
    localparam int COARSE_W   = 6;
    localparam int FINE_LSB   = 0;
    localparam int FINE_W     = 5;

    // Mode and gain fields
    localparam int MODE_LSB        = 8;
    localparam int MODE_W          = 8;
    localparam int IND_GAIN_BIT    = 6;
    localparam int COMMON_GAIN_LSB = 0;
    localparam logic [7:0] MODE_NORMAL = 8'h1c;
    localparam logic [7:0] MODE_DIGINT = 8'h1d;

    // Path connection codes
    localparam logic [15:0] PATH_FULL    = 16'hada5;
    localparam logic [15:0] PATH_TIA_ADC = 16'hb065;
    localparam logic [15:0] PATH_DIGINT  = 16'hae65;

    // Shared gain and power register fields
    localparam int PWR_LSB          = 13;
    localparam int PWR_W            = 3;
    localparam int SLOT_B_GAIN_LSB  = 6;
    localparam int SLOT_A_GAIN_LSB  = 0;
    localparam logic [2:0] PWR_ALL_ON   = 3'h0;
    localparam logic [2:0] PWR_DOWN_234 = 3'h7;

    // Stage enables, bit 3 TIA, bit 2 band-pass, bit 1 integrator, bit 0 converter
    localparam logic [3:0] STAGES_ALL     = 4'hf;
    localparam logic [3:0] STAGES_TIA_ADC = 4'h9;
    localparam logic [3:0] STAGES_NONE    = 4'h0;

    // Timing
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int US_PS          = 1000000;
    localparam int FINE_STEP_PS   = 31250;
    localparam int CYC_PER_US     = US_PS / CLK_PERIOD_PS;
    localparam int FINE_PER_US    = US_PS / FINE_STEP_PS;
    localparam int CYC_W          = 13;
    localparam int START_W        = 11;

    typedef enum logic [1:0] {
        AFC_PATH_FULL,
        AFC_PATH_TIA_ADC,
        AFC_PATH_DIGINT,
        AFC_PATH_RESERVED
    } afc_path_t;

    typedef enum logic {
        AFC_MODE_NORMAL,
        AFC_MODE_DIGINT
    } afc_mode_t;

    function automatic logic [KOHM_W-1:0] gain_kohm(input logic [GAIN_W-1:0] code);
        logic [KOHM_W-1:0] k;
        k = 8'hc8;
        unique case (code)
            2'h0: k = 8'hc8;
            2'h1: k = 8'h64;
            2'h2: k = 8'h32;
            2'h3: k = 8'h19;
        endcase
        return k;
    endfunction

endpackage

// *** logic/afc_gain_decode.sv ***
// One channel gain stage: registers a two-bit gain code and its resistance.
// Assumes the code is a settled register field in the same clock domain.
module afc_gain_decode (
    input  wire logic                       i_mclk,
    input  wire logic                       i_srst,
    input  wire logic [afc_pkg::GAIN_W-1:0] i_code,
    output logic      [afc_pkg::GAIN_W-1:0] o_code,
    output logic      [afc_pkg::KOHM_W-1:0] o_kohm
);

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_code <= '0;
            o_kohm <= afc_pkg::gain_kohm(2'h0);
        end else begin
            o_code <= i_code;
            o_kohm <= afc_pkg::gain_kohm(i_code);
        end
    end

    a_kohm_tracks_code: assert property (@(posedge i_mclk) disable iff (i_srst)
        ##1 !$past(i_srst) |-> o_kohm == afc_pkg::gain_kohm(o_code))
        else $error("gain resistance does not match its code");

endmodule

// *** logic/afc_slot_a_regs.sv ***
// First-slot front-end configuration bank: four 16-bit registers and the
// settings derived from them for the analog chain and the timing core.
// Assumes the serial decoder presents one-cycle read and write strobes.
// Behaviour
// - Window width from bits 15:11, one microsecond steps, reset code 4.
// - Coarse window delay from bits 10:5, one microsecond steps, reset 0x17.
// - Fine window delay from bits 4:0, 31.25 ns steps, reset 0x1C.
// - Mode byte 0x1C selects normal, 0x1D selects digital integrate.
// - Normal mode uses amplifier, band-pass, integrator and converter in turn.
// - Individual gain set: channel 1 from mode bits, others from shared register.
// - Individual gain clear: common two-bit code applies to all four channels.
// - Gain codes 0..3 mean 200, 100, 50, 25 kilohms.
// - Path word 0xADA5 full, 0xB065 amplifier-converter, 0xAE65 integration.
// - Power field 7 powers down channels 2-4 in integration mode.
// - Shared register holds second-slot gains for channels 4,3,2 at 11:6.
// - Shared register holds first-slot gains for channels 4,3,2 at 5:0.
// - Gapped integration uses the fine field as the gap in microseconds.
// - Integration mode only when the separate enable bit is set.
module afc_slot_a_regs (
    input  wire logic                        i_mclk,
    input  wire logic                        i_srst,
    input  wire logic                        i_reg_wr_en,
    input  wire logic                        i_reg_rd_en,
    input  wire logic [afc_pkg::ADDR_W-1:0]  i_reg_addr,
    input  wire logic [afc_pkg::DATA_W-1:0]  i_reg_wdata,
    input  wire logic                        i_first_slot_integration_enable,
    input  wire logic                        i_integration_gap_enable,
    output logic      [afc_pkg::DATA_W-1:0]  o_reg_rdata,
    output logic                             o_reg_rvalid,
    output logic                             o_reg_hit,
    output logic      [afc_pkg::CYC_W-1:0]   o_window_width_cycles,
    output logic      [afc_pkg::START_W-1:0] o_window_start_steps,
    output logic      [afc_pkg::CYC_W-1:0]   o_integration_gap_cycles,
    output logic                             o_digital_mode,
    output logic      [3:0]                  o_stage_enable,
    output logic                             o_path_reserved,
    output logic      [7:0]                  o_first_slot_gain_codes,
    output logic      [31:0]                 o_first_slot_gain_kohm,
    output logic      [5:0]                  o_second_slot_gain_codes,
    output logic      [23:0]                 o_second_slot_gain_kohm,
    output logic      [2:0]                  o_channel_powerdown
);

    logic [15:0] slot_a_window_timing;
    logic [15:0] slot_a_frontend_mode_gain;
    logic [15:0] slot_a_path_connection;
    logic [15:0] channel_gain_and_power;

    logic [afc_pkg::WIDTH_W-1:0]  first_slot_window_width;
    logic [afc_pkg::COARSE_W-1:0] first_slot_window_coarse_delay;
    logic [afc_pkg::FINE_W-1:0]   first_slot_window_fine_delay;
    logic [afc_pkg::MODE_W-1:0]   first_slot_frontend_mode;
    logic                         first_slot_individual_gain_enable;
    logic [1:0]                   first_slot_common_gain;
    logic [2:0]                   integration_channel_powerdown;
    logic [7:0]                   next_first_gain;
    logic [5:0]                   second_gain;
    logic                         addr_hit;
    afc_pkg::afc_path_t           path_sel;
    afc_pkg::afc_mode_t           next_mode;

    assign first_slot_window_width =
        slot_a_window_timing[afc_pkg::WIDTH_LSB +: afc_pkg::WIDTH_W];
    assign first_slot_window_coarse_delay =
        slot_a_window_timing[afc_pkg::COARSE_LSB +: afc_pkg::COARSE_W];
    assign first_slot_window_fine_delay =
        slot_a_window_timing[afc_pkg::FINE_LSB +: afc_pkg::FINE_W];
    assign first_slot_frontend_mode =
        slot_a_frontend_mode_gain[afc_pkg::MODE_LSB +: afc_pkg::MODE_W];
    assign first_slot_individual_gain_enable =
        slot_a_frontend_mode_gain[afc_pkg::IND_GAIN_BIT];
    assign first_slot_common_gain =
        slot_a_frontend_mode_gain[afc_pkg::COMMON_GAIN_LSB +: afc_pkg::GAIN_W];
    assign integration_channel_powerdown =
        channel_gain_and_power[afc_pkg::PWR_LSB +: afc_pkg::PWR_W];
    assign second_gain = channel_gain_and_power[afc_pkg::SLOT_B_GAIN_LSB +: 6];

    assign addr_hit = (i_reg_addr == afc_pkg::ADDR_WINDOW) ||
                      (i_reg_addr == afc_pkg::ADDR_MODE) ||
                      (i_reg_addr == afc_pkg::ADDR_PATH) ||
                      (i_reg_addr == afc_pkg::ADDR_GAIN);

    // Reserved bits are stored as written; the host keeps their fixed patterns.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            slot_a_window_timing      <= afc_pkg::RST_WINDOW;
            slot_a_frontend_mode_gain <= afc_pkg::RST_MODE;
            slot_a_path_connection    <= afc_pkg::RST_PATH;
            channel_gain_and_power    <= afc_pkg::RST_GAIN;
        end else if (i_reg_wr_en) begin
            unique case (i_reg_addr)
                afc_pkg::ADDR_WINDOW: slot_a_window_timing      <= i_reg_wdata;
                afc_pkg::ADDR_MODE:   slot_a_frontend_mode_gain <= i_reg_wdata;
                afc_pkg::ADDR_PATH:   slot_a_path_connection    <= i_reg_wdata;
                afc_pkg::ADDR_GAIN:   channel_gain_and_power    <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Read answer one cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_reg_rdata  <= '0;
            o_reg_rvalid <= 1'b0;
            o_reg_hit    <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd_en;
            o_reg_hit    <= (i_reg_rd_en || i_reg_wr_en) && addr_hit;
            if (i_reg_rd_en) begin
                unique case (i_reg_addr)
                    afc_pkg::ADDR_WINDOW: o_reg_rdata <= slot_a_window_timing;
                    afc_pkg::ADDR_MODE:   o_reg_rdata <= slot_a_frontend_mode_gain;
                    afc_pkg::ADDR_PATH:   o_reg_rdata <= slot_a_path_connection;
                    afc_pkg::ADDR_GAIN:   o_reg_rdata <= channel_gain_and_power;
                    default:              o_reg_rdata <= '0;
                endcase
            end
        end
    end

    function automatic afc_pkg::afc_path_t decode_path(input logic [15:0] word);
        afc_pkg::afc_path_t p;
        p = afc_pkg::AFC_PATH_RESERVED;
        unique case (word)
            afc_pkg::PATH_FULL:    p = afc_pkg::AFC_PATH_FULL;
            afc_pkg::PATH_TIA_ADC: p = afc_pkg::AFC_PATH_TIA_ADC;
            afc_pkg::PATH_DIGINT:  p = afc_pkg::AFC_PATH_DIGINT;
            default:               p = afc_pkg::AFC_PATH_RESERVED;
        endcase
        return p;
    endfunction

    assign path_sel = decode_path(slot_a_path_connection);

    // Integration needs both the mode byte and the separate enable; a stray
    // mode byte alone must not switch the chain away from normal operation.
    assign next_mode = (i_first_slot_integration_enable &&
                        first_slot_frontend_mode == afc_pkg::MODE_DIGINT) ?
                       afc_pkg::AFC_MODE_DIGINT : afc_pkg::AFC_MODE_NORMAL;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_digital_mode  <= 1'b0;
            o_stage_enable  <= afc_pkg::STAGES_ALL;
            o_path_reserved <= 1'b0;
        end else begin
            o_digital_mode  <= (next_mode == afc_pkg::AFC_MODE_DIGINT);
            o_path_reserved <= (path_sel == afc_pkg::AFC_PATH_RESERVED);
            if (next_mode == afc_pkg::AFC_MODE_NORMAL) begin
                o_stage_enable <= afc_pkg::STAGES_ALL;
            end else begin
                unique case (path_sel)
                    afc_pkg::AFC_PATH_FULL:     o_stage_enable <= afc_pkg::STAGES_ALL;
                    afc_pkg::AFC_PATH_TIA_ADC:  o_stage_enable <= afc_pkg::STAGES_TIA_ADC;
                    afc_pkg::AFC_PATH_DIGINT:   o_stage_enable <= afc_pkg::STAGES_TIA_ADC;
                    afc_pkg::AFC_PATH_RESERVED: o_stage_enable <= afc_pkg::STAGES_NONE;
                endcase
            end
        end
    end

    // Window timing in clock cycles and in fine steps from the slot start.
    // In gapped mode the fine field is a gap, so the start loses its fine part.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_window_width_cycles    <= '0;
            o_window_start_steps     <= '0;
            o_integration_gap_cycles <= '0;
        end else begin
            o_window_width_cycles <= afc_pkg::CYC_W'(first_slot_window_width *
                                                     afc_pkg::CYC_PER_US);
            if (i_integration_gap_enable) begin
                o_window_start_steps     <= afc_pkg::START_W'(
                    first_slot_window_coarse_delay * afc_pkg::FINE_PER_US);
                o_integration_gap_cycles <= afc_pkg::CYC_W'(
                    first_slot_window_fine_delay * afc_pkg::CYC_PER_US);
            end else begin
                o_window_start_steps     <= afc_pkg::START_W'(
                    first_slot_window_coarse_delay * afc_pkg::FINE_PER_US +
                    first_slot_window_fine_delay);
                o_integration_gap_cycles <= '0;
            end
        end
    end

    // Per-channel first-slot gain selection, channel 1 in the low pair
    always_comb begin
        next_first_gain[1:0] = first_slot_common_gain;
        for (int c = 1; c < afc_pkg::NUM_CH; c++) begin
            if (first_slot_individual_gain_enable) begin
                next_first_gain[2*c +: 2] =
                    channel_gain_and_power[afc_pkg::SLOT_A_GAIN_LSB + 2*(c-1) +: 2];
            end else begin
                next_first_gain[2*c +: 2] = first_slot_common_gain;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < afc_pkg::NUM_CH; g++) begin : g_first
            afc_gain_decode u_dec (
                .i_mclk (i_mclk),
                .i_srst (i_srst),
                .i_code (next_first_gain[2*g +: 2]),
                .o_code (o_first_slot_gain_codes[2*g +: 2]),
                .o_kohm (o_first_slot_gain_kohm[8*g +: 8])
            );
        end
        for (g = 0; g < afc_pkg::NUM_CH - 1; g++) begin : g_second
            afc_gain_decode u_dec (
                .i_mclk (i_mclk),
                .i_srst (i_srst),
                .i_code (second_gain[2*g +: 2]),
                .o_code (o_second_slot_gain_codes[2*g +: 2]),
                .o_kohm (o_second_slot_gain_kohm[8*g +: 8])
            );
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_channel_powerdown <= '0;
        end else begin
            o_channel_powerdown <= {3{next_mode == afc_pkg::AFC_MODE_DIGINT &&
                integration_channel_powerdown == afc_pkg::PWR_DOWN_234}};
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    // The cycle count is registered from the field, so it lags release by one edge
    a_width_reset: assert property ($fell(i_srst) |->
        first_slot_window_width == 5'h4 ##1 o_window_width_cycles == 13'h1f4)
        else $error("window width default wrong");

    a_coarse_write: assert property (i_reg_wr_en && i_reg_addr == 8'h39 |=>
        first_slot_window_coarse_delay == $past(i_reg_wdata[10:5]))
        else $error("coarse delay field not stored");

    a_fine_start: assert property (!i_integration_gap_enable |=>
        o_window_start_steps == 11'($past(first_slot_window_coarse_delay) * 32
                                    + $past(first_slot_window_fine_delay)))
        else $error("window start steps wrong");

    a_mode_needs_en: assert property (!i_first_slot_integration_enable |=>
        !o_digital_mode ##0 o_stage_enable == 4'hf)
        else $error("integration mode without enable");

    a_normal_stages: assert property (first_slot_frontend_mode == 8'h1c |=>
        o_stage_enable == 4'hf)
        else $error("normal mode byte did not select full chain");

    a_common_gain: assert property (!first_slot_individual_gain_enable |-> ##1
        o_first_slot_gain_codes == {4{$past(first_slot_common_gain)}})
        else $error("common gain not applied to all channels");

    a_indiv_gain: assert property (first_slot_individual_gain_enable |-> ##1
        o_first_slot_gain_codes == {$past(channel_gain_and_power[5:0]),
                                    $past(first_slot_common_gain)})
        else $error("individual gains not taken from shared register");

    a_second_gain: assert property (##1 1'b1 |->
        o_second_slot_gain_codes == $past(channel_gain_and_power[11:6]))
        else $error("second slot gains wrong");

    a_powerdown: assert property (o_channel_powerdown != 3'h0 |->
        o_digital_mode && $past(integration_channel_powerdown) == 3'h7)
        else $error("channels powered down outside integration");

    a_gap_value: assert property (i_integration_gap_enable |=>
        o_integration_gap_cycles == 13'($past(first_slot_window_fine_delay) * 125))
        else $error("integration gap wrong");

    a_path_decode: assert property (slot_a_path_connection == afc_pkg::PATH_TIA_ADC |=>
        !o_path_reserved)
        else $error("valid path word flagged reserved");

    a_path_reserved: assert property (slot_a_path_connection != afc_pkg::PATH_FULL &&
        slot_a_path_connection != afc_pkg::PATH_TIA_ADC &&
        slot_a_path_connection != afc_pkg::PATH_DIGINT |=> o_path_reserved)
        else $error("reserved path word not flagged");

    a_digint_stages: assert property (i_first_slot_integration_enable &&
        first_slot_frontend_mode == afc_pkg::MODE_DIGINT &&
        slot_a_path_connection == afc_pkg::PATH_DIGINT |=>
        o_digital_mode && o_stage_enable == 4'h9)
        else $error("integration path did not select amplifier and converter");

    a_powerdown_set: assert property (o_digital_mode &&
        $past(integration_channel_powerdown) == afc_pkg::PWR_DOWN_234 |->
        o_channel_powerdown == 3'h7)
        else $error("channels not powered down in integration");

    a_read_path: assert property (i_reg_rd_en && i_reg_addr == afc_pkg::ADDR_PATH |=>
        o_reg_rvalid && o_reg_hit && o_reg_rdata == $past(slot_a_path_connection))
        else $error("path register read back wrong");

    c_digint: cover property (o_digital_mode && o_stage_enable == 4'h9);
    c_indiv: cover property (first_slot_individual_gain_enable ##1
        o_first_slot_gain_codes[1:0] != o_first_slot_gain_codes[3:2]);
    c_gap: cover property (i_integration_gap_enable && o_integration_gap_cycles != 0);
    c_pd: cover property (o_channel_powerdown == 3'h7);
    c_reserved: cover property (o_digital_mode && o_path_reserved && o_stage_enable == 4'h0);

endmodule

// *** sim/afc_host_model.sv ***
// Host-side register master for the first-slot configuration bank.
// Assumes strobes are taken on a rising edge and answered one edge later.
module afc_host_model (
    input  wire logic                        i_mclk,
    input  wire logic [afc_pkg::DATA_W-1:0]  i_reg_rdata,
    input  wire logic                        i_reg_rvalid,
    input  wire logic                        i_reg_hit,
    output logic                             o_reg_wr_en,
    output logic                             o_reg_rd_en,
    output logic      [afc_pkg::ADDR_W-1:0]  o_reg_addr,
    output logic      [afc_pkg::DATA_W-1:0]  o_reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_reg_wr_en = 1'b0;
        o_reg_rd_en = 1'b0;
        o_reg_addr  = 8'h00;
        o_reg_wdata = 16'h0000;
    end

    task automatic write_reg(input logic [7:0] a, input logic [15:0] d, output logic hit);
        @(negedge i_mclk);
        o_reg_addr  = a;
        o_reg_wdata = d;
        o_reg_wr_en = 1'b1;
        @(negedge i_mclk);
        o_reg_wr_en = 1'b0;
        // Released lines show the inverse, so a stale value never passes for a live one
        o_reg_addr  = ~a;
        o_reg_wdata = ~d;
        hit         = i_reg_hit;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [15:0] q, output logic v,
                            output logic hit);
        @(negedge i_mclk);
        o_reg_addr  = a;
        o_reg_rd_en = 1'b1;
        @(negedge i_mclk);
        o_reg_rd_en = 1'b0;
        o_reg_addr  = ~a;
        q           = i_reg_rdata;
        v           = i_reg_rvalid;
        hit         = i_reg_hit;
    endtask
endmodule

// *** sim/afc_slot_a_regs_tb_top.sv ***
// Self-checking bench for the first-slot configuration bank.
// Assumes the host model drives the register port at the falling edge.
module afc_slot_a_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_mclk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_en   = 1'b0;
    logic        i_gap  = 1'b0;
    logic        wr_en, rd_en, rvalid, hit, dmode, pres;
    logic [7:0]  addr, ga_codes;
    logic [15:0] wdata, rdata;
    logic [12:0] width_cyc, gap_cyc;
    logic [10:0] start_steps;
    logic [3:0]  stages;
    logic [31:0] ga_kohm;
    logic [5:0]  gb_codes;
    logic [23:0] gb_kohm;
    logic [2:0]  pdown;
    int          miscompares = 0;
    int          num_checks  = 0;

    always #4 i_mclk = ~i_mclk;

    afc_host_model host (.i_mclk(i_mclk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
        .i_reg_hit(hit), .o_reg_wr_en(wr_en), .o_reg_rd_en(rd_en), .o_reg_addr(addr),
        .o_reg_wdata(wdata));

    afc_slot_a_regs DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_reg_wr_en(wr_en),
        .i_reg_rd_en(rd_en), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_first_slot_integration_enable(i_en), .i_integration_gap_enable(i_gap),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_reg_hit(hit),
        .o_window_width_cycles(width_cyc), .o_window_start_steps(start_steps),
        .o_integration_gap_cycles(gap_cyc), .o_digital_mode(dmode),
        .o_stage_enable(stages), .o_path_reserved(pres), .o_first_slot_gain_codes(ga_codes),
        .o_first_slot_gain_kohm(ga_kohm), .o_second_slot_gain_codes(gb_codes),
        .o_second_slot_gain_kohm(gb_kohm), .o_channel_powerdown(pdown));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] kohm(input logic [1:0] c);
        return (c == 2'h0) ? 8'hc8 : (c == 2'h1) ? 8'h64 : (c == 2'h2) ? 8'h32 : 8'h19;
    endfunction

    // Write, expect a hit, then let the derived outputs settle two edges later
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic h;
        host.write_reg(a, d, h);
        check(h, 1'b1);
        repeat (2) @(negedge i_mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic eh);
        logic [15:0] q;
        logic        v;
        logic        h;
        host.read_reg(a, q, v, h);
        check(v, 1'b1);
        check(h, eh);
        check(q, e);
    endtask

    task automatic t_reset();
        rd(afc_pkg::ADDR_WINDOW, {5'h4, 6'h17, 5'h1c}, 1'b1);
        rd(afc_pkg::ADDR_MODE, {8'h1c, 2'h0, 4'he, 2'h0}, 1'b1);
        rd(afc_pkg::ADDR_PATH, 16'hada5, 1'b1);
        rd(afc_pkg::ADDR_GAIN, 16'h0000, 1'b1);
        rd(8'h40, 16'h0000, 1'b0);
        check(width_cyc, 32'h1f4);
        check(start_steps, 32'h2fc);
        check({dmode, stages, pres, pdown}, {1'b0, 4'hf, 1'b0, 3'h0});
        check(ga_kohm, 32'hc8c8c8c8);
        check({gb_kohm, gb_codes}, {24'hc8c8c8, 6'h00});
    endtask

    task automatic t_window();
        logic [4:0] w [3] = '{5'h00, 5'h1f, 5'h01};
        logic [5:0] c [3] = '{6'h00, 6'h3f, 6'h01};
        logic [4:0] f [3] = '{5'h00, 5'h1f, 5'h01};
        for (int i = 0; i < 3; i++) begin
            for (int g = 0; g < 2; g++) begin
                i_gap = g[0];
                wr(afc_pkg::ADDR_WINDOW, {w[i], c[i], f[i]});
                check(width_cyc, w[i] * 125);
                check(start_steps, g ? c[i] * 32 : c[i] * 32 + f[i]);
                check(gap_cyc, g ? f[i] * 125 : 0);
                rd(afc_pkg::ADDR_WINDOW, {w[i], c[i], f[i]}, 1'b1);
            end
        end
    endtask

    task automatic t_gain();
        logic [1:0] a2, a3, a4;
        for (int k = 0; k < 8; k++) begin
            a2 = k[1:0] + 2'h1;
            a3 = k[1:0] + 2'h2;
            a4 = k[1:0] + 2'h3;
            wr(afc_pkg::ADDR_MODE, {8'h1c, 1'b0, k[2], 4'hd, k[1:0]});
            wr(afc_pkg::ADDR_GAIN, {4'h0, a2, a3, a4, a4, a3, a2});
            if (k[2]) begin
                check(ga_codes, {a4, a3, a2, k[1:0]});
                check(ga_kohm, {kohm(a4), kohm(a3), kohm(a2), kohm(k[1:0])});
            end else begin
                check(ga_codes, {4{k[1:0]}});
                check(ga_kohm, {4{kohm(k[1:0])}});
            end
            check(gb_codes, {a2, a3, a4});
            check(gb_kohm, {kohm(a2), kohm(a3), kohm(a4)});
        end
    endtask

    task automatic t_path();
        logic [15:0] p [4] = '{16'hada5, 16'hb065, 16'hae65, 16'h1234};
        logic [3:0]  s [4] = '{4'hf, 4'h9, 4'h9, 4'h0};
        logic        dig;
        for (int i = 0; i < 32; i++) begin
            i_en = i[3];
            dig  = i[3] & i[2];
            wr(afc_pkg::ADDR_PATH, p[i[1:0]]);
            wr(afc_pkg::ADDR_MODE, {i[2] ? 8'h1d : 8'h1c, 8'h34});
            wr(afc_pkg::ADDR_GAIN, {i[4] ? 3'h7 : 3'h3, 13'h0000});
            check(dmode, dig);
            check(stages, dig ? s[i[1:0]] : 4'hf);
            check(pres, i[1:0] == 2'h3);
            check(pdown, (dig && i[4]) ? 3'h7 : 3'h0);
        end
    endtask

    task automatic t_unmapped();
        logic h;
        host.write_reg(8'h41, 16'hffff, h);
        check(h, 1'b0);
        rd(8'h41, 16'h0000, 1'b0);
        rd(afc_pkg::ADDR_GAIN, {3'h7, 13'h0000}, 1'b1);
    endtask

    initial begin
        repeat (16) @(negedge i_mclk);
        i_srst = 1'b0;
        repeat (2) @(negedge i_mclk);
        t_reset();
        t_window();
        t_gain();
        t_path();
        t_unmapped();
        complete_run();
    end

    // Whole run needs about five hundred cycles; twelve and a half thousand means a hang
    initial begin
        #100us;
        miscompares++;
        complete_run();
    end
endmodule
